/* File: inc/srwf_cfg.svh */
`ifndef SRWF_CFG_SVH
`define SRWF_CFG_SVH
// Reply word field positions.
`define SRWF_STAT_HI_BIT     15
`define SRWF_STAT_LO_BIT     14
`define SRWF_PARITY_BIT      13
`define SRWF_LOST_BIT        12
// Status encodings.
`define SRWF_STS_OFF         2'h0
`define SRWF_STS_ON_NOPROC   2'h1
`define SRWF_STS_ON_PROC     2'h2
`define SRWF_STS_CFG         2'h3
// Fault codes.
`define SRWF_FC_NONE         12'h000
`define SRWF_FC_MIN          12'h001
`define SRWF_FC_BAD_BITCNT   12'h002
`define SRWF_FC_CUR_LIMIT    12'h010
`define SRWF_FC_SPI_PARITY   12'h012
`define SRWF_FC_RSVD_MSG     12'h018
`define SRWF_FC_BIT_TIME     12'h019
`define SRWF_FC_FEW_BITS     12'h01A
`define SRWF_FC_TOO_MANY     12'h01A
`define SRWF_FC_CRC          12'h01C
`define SRWF_FC_MAX          12'h01F
`define SRWF_A_DATA_MIN      12'h020
`define SRWF_B_DATA_FLAG     12'h800
// Fixed reply of channel two after reset.
`define SRWF_CH2_RESET_WORD  16'hE000
// Reset reply of channel one: configuration report of zero content; bit 13
// is set because the other ones, two of them, are even in number.
`define SRWF_CH1_RESET_WORD  16'hE000
// B protocol field length base (code 0 means 8 bits).
`define SRWF_B_LEN_BASE      4'h8
`endif

/* File: inc/srwf_pkg.sv */
package srwf_pkg;
    // Which fault kind a channel event carries.
    typedef enum logic [2:0] {
        SRWF_EV_CUR_LIMIT,
        SRWF_EV_SPI_PARITY,
        SRWF_EV_BIT_TIME,
        SRWF_EV_FEW_BITS,
        SRWF_EV_TOO_MANY,
        SRWF_EV_CRC
    } srwf_fault_t;
    // Protocol of a channel.
    typedef enum logic {
        SRWF_PROTO_A,
        SRWF_PROTO_B
    } srwf_proto_t;
endpackage : srwf_pkg

/* File: rtl/srwf_fifo2.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Two-entry reply buffer
// ----------------------------------------------------------------------
module srwf_fifo2 #(
    parameter int WIDTH = 12
) (
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,    // Empties both entries.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [2];           // Storage for the two entries.
    logic [WIDTH-1:0] next_mem [2];
    logic             rd_ptr;            // Oldest entry.
    logic             next_rd_ptr;
    logic [1:0]       count;             // Entries held, 0 to 2.
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];

    // Next state; flush wins over everything, since the host asked for it.
    always_comb begin
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        next_mem    = mem;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush_i) begin
            next_count  = 2'h0;
            next_rd_ptr = 1'b0;
        end else begin
            if (push) begin
                next_mem[rd_ptr ^ count[0]] = in_data_i;
            end
            if (pop) begin
                next_rd_ptr = ~rd_ptr;
            end
            next_count = count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Registers only.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            mem    <= next_mem;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    a_fifo_bound: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        count <= 2'h2) else $error("Buffer count above two.");
endmodule : srwf_fifo2
`default_nettype wire

/* File: rtl/srwf_reply.sv */
`timescale 1ns/10ps
`default_nettype none
`include "srwf_cfg.svh"
// ----------------------------------------------------------------------
// Satellite reply word formatter, one channel
// ----------------------------------------------------------------------
// How it works
// - Status bits latch at chip select fall.
// - Push codes; pop reported entry at rise.
// - Fault codes lie within 001 to 01F.
// - Channel faults per event; global once.
// - Bit 13 makes the word odd parity.
// - Bit 12 data lost; 11:0 buffer.
// - Word to full buffer dropped, flag set.
// - Status 00 off,01,10 on,11 config.
// - Zero means empty; 2 global, once.
// - A protocol channel fault code set.
// - A data below 020 raises reserved fault.
// - No fault, no data: field reads zero.
// - B protocol channel fault code set.
// - B data sets bit 11; faults clear it.
// - B data right justified, zero filled.
// - B length mismatch flags many or few.
// - Reset reply: config or E000 word.
// - Flush empties both buffer entries.
module srwf_reply
    import srwf_pkg::*;
#(
    parameter bit IS_CHANNEL_ONE = 1'b1    // Only channel one carries global faults.
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   cs_n_i,          // Satellite chip select, pin.
    input  wire logic                   chan_on_i,
    input  wire logic                   proc_en_i,
    input  wire logic                   cfg_report_i,    // Next reply is a configuration report.
    input  wire logic [12:0]            cfg_data_i,      // Configuration content to report.
    input  wire srwf_pkg::srwf_proto_t  proto_i,
    input  wire logic [1:0]             b_len_sel_i,     // B data length code.
    input  wire logic                   flush_i,         // Flush bit of a channel config write.
    input  wire logic                   fault_valid_i,   // One-cycle channel fault event.
    input  wire srwf_pkg::srwf_fault_t  fault_kind_i,
    input  wire logic                   global_fault_i,  // Level: bad serial bit count present.
    input  wire logic                   msg_valid_i,     // One-cycle decoded message.
    input  wire logic [11:0]            msg_data_i,      // Data bits, right aligned.
    input  wire logic [3:0]             msg_bits_i,      // Bits counted in the data field.
    output logic [15:0]                 reply_word_o,    // Word shifted out during a frame.
    output logic                        data_lost_flag_o
);
    import srwf_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Odd parity over the word with bit 13 cleared.
    function automatic logic [15:0] srwf_add_parity(input logic [15:0] w);
        logic [15:0] t;
        t = w;
        t[`SRWF_PARITY_BIT] = ~(^{w[15:14], w[12:0]});
        return t;
    endfunction : srwf_add_parity

    // Maps a fault kind to its code for the given protocol.
    // The A protocol has no too-many code of its own; the decoder never raises
    // that kind there, so it simply shares the B value.
    function automatic logic [11:0] srwf_code(input srwf_fault_t k, input srwf_proto_t p);
        logic [11:0] c;
        c = `SRWF_FC_NONE;
        case (k)
            SRWF_EV_CUR_LIMIT:  c = `SRWF_FC_CUR_LIMIT;
            SRWF_EV_SPI_PARITY: c = `SRWF_FC_SPI_PARITY;
            SRWF_EV_BIT_TIME:   c = `SRWF_FC_BIT_TIME;
            SRWF_EV_FEW_BITS:   c = (p == SRWF_PROTO_B) ? `SRWF_FC_BIT_TIME : `SRWF_FC_FEW_BITS;
            SRWF_EV_TOO_MANY:   c = `SRWF_FC_TOO_MANY;
            SRWF_EV_CRC:        c = `SRWF_FC_CRC;
            default:            c = `SRWF_FC_NONE;
        endcase
        return c;
    endfunction : srwf_code

    // ------------------------------------------------------------------
    // Chip select synchroniser and edges
    // ------------------------------------------------------------------
    logic cs_meta;        // First stage, read only by the second.
    logic cs_sync;        // Second stage.
    logic cs_prev;        // Previous synchronised level, for edges.
    logic cs_fall;
    logic cs_rise;
    assign cs_fall = cs_prev && !cs_sync;
    assign cs_rise = !cs_prev && cs_sync;

    // All three stages reset to the idle high level of the pin, so the
    // release of reset can never look like the start of a frame.
    // Registers for the synchroniser; the pin is async to mclk_i.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_n_i;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    // ------------------------------------------------------------------
    // Event selection into the buffer
    // ------------------------------------------------------------------
    logic        global_seen;       // Global fault already queued this episode.
    logic        next_global_seen;
    logic        ev_valid;
    logic [11:0] ev_data;
    logic        buf_ready;
    logic        buf_valid;
    logic [11:0] buf_data;
    logic        buf_pop;
    logic [3:0]  b_len;
    logic        b_len_err;

    // Picks at most one word per cycle: global fault, then channel fault,
    // then data. Simultaneous lower-priority events are lost; the source
    // sees no ready of its own, which keeps the decoder free-running.
    always_comb begin
        b_len     = `SRWF_B_LEN_BASE + {2'h0, b_len_sel_i};
        b_len_err = (proto_i == SRWF_PROTO_B) && (msg_bits_i != b_len);
        next_global_seen = global_seen;
        ev_valid  = 1'b0;
        ev_data   = `SRWF_FC_NONE;
        if (!global_fault_i) begin
            next_global_seen = 1'b0;
        end
        if (IS_CHANNEL_ONE && global_fault_i && !global_seen) begin
            ev_valid         = 1'b1;
            ev_data          = `SRWF_FC_BAD_BITCNT;
            next_global_seen = 1'b1;
        end else if (fault_valid_i) begin
            ev_valid = 1'b1;
            ev_data  = srwf_code(fault_kind_i, proto_i);
        end else if (msg_valid_i && b_len_err) begin
            ev_valid = 1'b1;
            ev_data  = (msg_bits_i > b_len) ? `SRWF_FC_TOO_MANY : `SRWF_FC_BIT_TIME;
        end else if (msg_valid_i && proto_i == SRWF_PROTO_B) begin
            ev_valid = 1'b1;
            ev_data  = `SRWF_B_DATA_FLAG
                     | (msg_data_i & ~(12'hFFF << b_len));
        end else if (msg_valid_i) begin
            ev_valid = 1'b1;
            ev_data  = (msg_data_i < `SRWF_A_DATA_MIN) ? `SRWF_FC_RSVD_MSG
                                                       : msg_data_i;
        end
    end

    // Episode memory: a global fault that drops and returns is queued again.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            global_seen <= 1'b0;
        end else begin
            global_seen <= next_global_seen;
        end
    end

    // ------------------------------------------------------------------
    // Two-entry buffer
    // ------------------------------------------------------------------
    srwf_fifo2 #(.WIDTH(12)) u_buf (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .flush_i     (flush_i),
        .in_valid_i  (ev_valid),
        .in_ready_o  (buf_ready),
        .in_data_i   (ev_data),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_data)
    );

    // ------------------------------------------------------------------
    // Reply word
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SRWF_R_IDLE, SRWF_R_FRAME} srwf_rstate_t;
    srwf_rstate_t rstate;            // Inside a chip select frame or not.
    srwf_rstate_t next_rstate;
    logic [15:0]  word;
    logic [15:0]  next_word;
    logic         reported;          // The frame shows a buffer entry.
    logic         next_reported;
    logic         lost;
    logic         next_lost;
    logic [1:0]   status;

    // Word is frozen at the falling edge and held for the whole frame;
    // the entry it shows leaves the buffer only when the frame ends.
    always_comb begin
        status        = !chan_on_i ? `SRWF_STS_OFF :
                        (proc_en_i ? `SRWF_STS_ON_PROC : `SRWF_STS_ON_NOPROC);
        next_rstate   = rstate;
        next_word     = word;
        next_reported = reported;
        next_lost     = lost;
        buf_pop       = 1'b0;
        if (ev_valid && !buf_ready) begin
            next_lost = 1'b1;
        end
        case (rstate)
            SRWF_R_IDLE: begin
                if (cs_fall) begin
                    next_rstate = SRWF_R_FRAME;
                    if (cfg_report_i) begin
                        next_word     = srwf_add_parity({`SRWF_STS_CFG, 1'b0, cfg_data_i});
                        next_reported = 1'b0;
                    end else begin
                        next_word = srwf_add_parity({status, 1'b0, lost,
                                    buf_valid ? buf_data : `SRWF_FC_NONE});
                        next_reported = buf_valid;
                    end
                end
            end
            SRWF_R_FRAME: begin
                if (cs_rise) begin
                    next_rstate   = SRWF_R_IDLE;
                    buf_pop       = reported;
                    next_reported = 1'b0;
                    // Clear only a flag that this frame's word carried; a loss after the fall
                    // reaches the host next time if the word showed no flag or it lands at the rise.
                    if (word[`SRWF_STAT_HI_BIT:`SRWF_STAT_LO_BIT] != `SRWF_STS_CFG
                        && word[`SRWF_LOST_BIT] && !(ev_valid && !buf_ready)) begin
                        next_lost = 1'b0;   // Flag delivered; new loss still wins.
                    end
                end
            end
            default: next_rstate = SRWF_R_IDLE;
        endcase
    end

    // Reset reply: configuration report for channel one, fixed word else.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rstate   <= SRWF_R_IDLE;
            word     <= IS_CHANNEL_ONE ? `SRWF_CH1_RESET_WORD
                                       : `SRWF_CH2_RESET_WORD;
            reported <= 1'b0;
            lost     <= 1'b0;
        end else begin
            rstate   <= next_rstate;
            word     <= next_word;
            reported <= next_reported;
            lost     <= next_lost;
        end
    end

    assign reply_word_o     = word;
    assign data_lost_flag_o = lost;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // The word latched at a frame start carries odd parity.
    a_parity_odd: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $past(cs_fall) |-> ^word)
        else $error("Reply word not odd parity.");
    // Every word shown, the reset words included, has odd parity.
    a_parity_all: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ^word)
        else $error("Reply word lost odd parity.");
    // Status bits come from the levels seen at the frame start.
    a_status_cause: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        cs_fall && !cfg_report_i |=> word[15:14] == $past(status))
        else $error("Status bits not latched at frame start.");
    // Nothing may change the word while the host shifts it out.
    a_word_held: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rstate == SRWF_R_FRAME && !cs_rise |=> $stable(word))
        else $error("Reply word changed inside frame.");
    // A word refused by a full buffer raises the lost flag.
    a_lost_set: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ev_valid && !buf_ready |=> lost)
        else $error("Lost flag missed.");
    // The lost flag only falls at the end of a frame whose word showed it.
    a_lost_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        lost && !(rstate == SRWF_R_FRAME && cs_rise && word[`SRWF_LOST_BIT]) |=> lost)
        else $error("Lost flag cleared before it was reported.");
    // The shown entry leaves the buffer only at the frame end.
    a_pop_at_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        buf_pop |-> cs_rise && reported)
        else $error("Pop outside frame end.");
    // A flush leaves the buffer empty on the next cycle.
    a_flush_empty: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        flush_i |=> !buf_valid)
        else $error("Buffer not empty after flush.");
    // Channel fault codes stay inside the fault range.
    a_fault_range: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        fault_valid_i && !global_fault_i |-> ev_data >= `SRWF_FC_MIN && ev_data <= `SRWF_FC_MAX)
        else $error("Fault code out of range.");
    // B sensor data always carries bit 11.
    a_b_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ev_valid && ev_data > `SRWF_FC_MAX && proto_i == SRWF_PROTO_B |-> ev_data[11])
        else $error("B data without bit 11.");
    // A global fault that stays present is queued once only.
    a_global_once: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        global_seen && global_fault_i |-> !(ev_valid && ev_data == `SRWF_FC_BAD_BITCNT))
        else $error("Global fault queued twice.");
endmodule : srwf_reply
`default_nettype wire

/* File: verif/srwf_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Host side model: frames the chip select and shifts the reply in
// ----------------------------------------------------------------------
module srwf_host (
    input  wire logic        mclk_i,      // Used only to place frame edges.
    input  wire logic [15:0] miso_word_i, // Reply word as presented at the pins.
    output logic             cs_n_o       // Chip select towards the device.
);
    logic sclk; // Serial clock, 32 ns, parked low outside frames.

    initial begin
        cs_n_o = 1'b1;
        sclk   = 1'b0;
    end

    // One full frame: the lead time before the first edge leaves room for the
    // device's synchroniser, as a real host would need to respect.
    task automatic frame(output logic [15:0] word);
        int i;
        @(posedge mclk_i);
        #1 cs_n_o = 1'b0;
        #48;
        for (i = 15; i >= 0; i--) begin
            sclk    = 1'b1;
            word[i] = miso_word_i[i];
            #16 sclk = 1'b0;
            #16;
        end
        @(posedge mclk_i);
        #1 cs_n_o = 1'b1;
        // Give the pop at the rising edge time to land before new traffic.
        repeat (8) @(posedge mclk_i);
    endtask : frame
endmodule : srwf_host
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench for the reply word formatter
// ----------------------------------------------------------------------
module tb;
    import srwf_pkg::*;
    logic        mclk, rstn, cs_n, on, proc, cfg_rep, flush, fv, glob, mv;
    logic [12:0] cfg_data;     // Configuration content shown in a report.
    logic [1:0]  len_sel;      // B data length code.
    logic [11:0] md;           // Message data, right aligned.
    logic [3:0]  mb;           // Message bit count.
    logic [15:0] w1, w2, cap;  // Parallel words of both channels, captured word.
    logic        lost1;        // Lost flag of channel one.
    srwf_proto_t proto;        // Protocol of both channels.
    srwf_fault_t fk;           // Kind of the pulsed fault.
    int          num_errors, checks_done, p, k, i;
    // Expected codes per fault kind; 0 marks a kind the A protocol lacks.
    logic [11:0] ca [6] = '{12'h010, 12'h012, 12'h019, 12'h01A, 12'h000, 12'h01C};
    logic [11:0] cb [6] = '{12'h010, 12'h012, 12'h019, 12'h019, 12'h01A, 12'h01C};

    srwf_reply #(.IS_CHANNEL_ONE(1'b1)) i_srwf_reply (.mclk_i(mclk), .rstn_i(rstn),
        .cs_n_i(cs_n), .chan_on_i(on), .proc_en_i(proc), .cfg_report_i(cfg_rep),
        .cfg_data_i(cfg_data), .proto_i(proto), .b_len_sel_i(len_sel), .flush_i(flush),
        .fault_valid_i(fv), .fault_kind_i(fk), .global_fault_i(glob), .msg_valid_i(mv),
        .msg_data_i(md), .msg_bits_i(mb), .reply_word_o(w1), .data_lost_flag_o(lost1));
    // Second channel sees the same traffic; only global faults must differ.
    srwf_reply #(.IS_CHANNEL_ONE(1'b0)) i_srwf_reply_ch2 (.mclk_i(mclk), .rstn_i(rstn),
        .cs_n_i(cs_n), .chan_on_i(on), .proc_en_i(proc), .cfg_report_i(cfg_rep),
        .cfg_data_i(cfg_data), .proto_i(proto), .b_len_sel_i(len_sel), .flush_i(flush),
        .fault_valid_i(fv), .fault_kind_i(fk), .global_fault_i(glob), .msg_valid_i(mv),
        .msg_data_i(md), .msg_bits_i(mb), .reply_word_o(w2), .data_lost_flag_o());
    srwf_host i_srwf_host (.mclk_i(mclk), .miso_word_i(w1), .cs_n_o(cs_n));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Odd parity over the whole word: bit 13 makes the count of ones odd.
    function automatic logic [15:0] ew(input logic [1:0] st, input logic l,
                                       input logic [11:0] d);
        ew = {st, ~^{st, l, d}, l, d};
    endfunction : ew

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic fault(input srwf_fault_t kind);
        tick;
        fv = 1'b1;
        fk = kind;
        tick;
        fv = 1'b0;
    endtask : fault

    task automatic msg(input logic [11:0] d, input logic [3:0] b);
        tick;
        mv = 1'b1;
        md = d;
        mb = b;
        tick;
        mv = 1'b0;
    endtask : msg

    // One host frame, then compare the word that was shifted out.
    task automatic rd(input string what, input logic [15:0] e);
        i_srwf_host.frame(cap);
        chk(what, e, cap);
    endtask : rd

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // The whole sequence needs about 20 us; five times that means a hang.
    initial begin
        #100000;
        num_errors++;
        conclude();
    end

    initial begin
        {rstn, on, proc, cfg_rep, flush, fv, glob, mv} = '0;
        {cfg_data, len_sel, md, mb, num_errors, checks_done} = '0;
        proto = SRWF_PROTO_A;
        fk    = SRWF_EV_CUR_LIMIT;
        repeat (10) @(posedge mclk);
        #1 rstn = 1'b1;
        tick;
        chk("reset ch1", ew(2'b11, 1'b0, 12'h000), w1);
        chk("reset ch2", 16'hE000, w2);
        chk("reset lost", 16'h0000, {15'h0, lost1});
        cfg_rep  = 1'b1;
        cfg_data = 13'h1A5C;
        rd("cfg report", ew(2'b11, 1'b1, 12'hA5C));
        cfg_rep  = 1'b0;
        // Off, on without processing, on with processing; queue stays empty.
        for (i = 0; i < 3; i++) begin
            on   = (i != 0);
            proc = (i == 2);
            rd("status", ew(i[1:0], 1'b0, 12'h000));
        end
        // Every channel fault kind in both protocols except too-many under A, one frame each.
        for (p = 0; p < 2; p++) begin
            proto = srwf_proto_t'(p);
            for (k = 0; k < 6; k++) begin
                if (p == 0 && k == 4) continue;
                fault(srwf_fault_t'(k));
                rd("fault", ew(2'b10, 1'b0, p ? cb[k] : ca[k]));
            end
        end
        proto = SRWF_PROTO_A;
        msg(12'h345, 4'hC);
        rd("a data", ew(2'b10, 1'b0, 12'h345));
        msg(12'h015, 4'hC);
        rd("a reserved", ew(2'b10, 1'b0, 12'h018));
        // B data with stray upper bits: only the configured length survives.
        proto = SRWF_PROTO_B;
        for (i = 0; i < 4; i++) begin
            len_sel = i[1:0];
            msg(12'hFFF, 4'(8 + i));
            rd("b data", ew(2'b10, 1'b0, 12'h800 | ((12'h1 << (8 + i)) - 12'h1)));
        end
        len_sel = 2'h0;
        msg(12'h0AA, 4'h9);
        rd("b many", ew(2'b10, 1'b0, 12'h01A));
        msg(12'h055, 4'h7);
        rd("b few", ew(2'b10, 1'b0, 12'h019));
        // Host stalls while three events arrive; the third finds the buffer full.
        fault(SRWF_EV_CUR_LIMIT);
        fault(SRWF_EV_CUR_LIMIT);
        fault(SRWF_EV_CRC);
        tick;
        chk("lost flag", 16'h0001, {15'h0, lost1});
        rd("overflow 1", ew(2'b10, 1'b1, 12'h010));
        rd("overflow 2", ew(2'b10, 1'b0, 12'h010));
        rd("overflow 3", ew(2'b10, 1'b0, 12'h000));
        // Flush written by the host empties both entries.
        fault(SRWF_EV_SPI_PARITY);
        fault(SRWF_EV_CRC);
        tick;
        flush = 1'b1;
        tick;
        flush = 1'b0;
        rd("flush", ew(2'b10, 1'b0, 12'h000));
        // A global fault held high is queued once, on channel one only.
        glob = 1'b1;
        repeat (4) tick;
        rd("global 1", ew(2'b10, 1'b0, 12'h002));
        chk("global ch2", ew(2'b10, 1'b0, 12'h000), w2);
        rd("global 2", ew(2'b10, 1'b0, 12'h000));
        glob = 1'b0;
        conclude();
    end
endmodule : tb
`default_nettype wire
